/* File: design/pmr_pkg.sv */
// What this block does
// [RQ1] Upper mode strap low advertises D0-D3; high advertises no power states.
// [RQ2] PME support field of the capability word always reads zero.
// [RQ3] D2 and D1 support bits read 1 when lower strap is 0, else 0; code reads 0 whenever upper strap is 1.
// [RQ4] Capability bits 8 to 6 always read zero.
// [RQ5] Device-specific-initialization bit reads zero.
// [RQ6] Auxiliary power and PME clock bits both read zero.
// [RQ7] Version field reads 001 with lower strap 1, 010 with lower strap 0; code reads 001 whenever upper strap is 1.
// [RQ8] Wake-event status bit 15 of control/status always reads zero.
// [RQ9] Data-scale and data-select fields read zero.
// [RQ10] Wake-signaling enable bit 8 reads zero and cannot be set.
// [RQ11] Control/status bits 7 to 2 read zero.
// [RQ12] Host writes power state in bits 1:0; device reports it there.
// [RQ13] Leaving D3hot for D0 pulses an internal reset, registers untouched.
// [RQ14] Bridge-support bit 7 mirrors the bus power/clock strap.
// [RQ15] Bridge-support bit 6 mirrors the strap; when set, D3hot stops secondary clocks.
// [RQ16] Secondary clocks derive from the primary clock and stop with it.
// [RQ17] Power data byte always reads 00h.
// [RQ18] Writes to read-only or reserved bits are ignored.
//
// Purpose: constants and state type of the power-management register bank
// Assumes: byte offsets within configuration space, dword-wide accesses
// Notes:   power-state codes follow the two-bit field encoding
package pmr_pkg;
  localparam logic [7:0]  CAPS_OFF        = 8'hDE;
  localparam logic [7:0]  CSR_OFF         = 8'hE0;
  localparam logic [7:0]  BRIDGE_OFF      = 8'hE2;
  localparam logic [7:0]  DATA_OFF        = 8'hE3;
  localparam logic [15:0] CAPS_FULL       = 16'h0602;
  localparam logic [15:0] CAPS_NONE       = 16'h0001;
  localparam logic [2:0]  VER_REV10       = 3'h1;
  localparam logic [2:0]  VER_REV11       = 3'h2;
  localparam logic [15:0] CSR_RESET       = 16'h0000;
  localparam logic [7:0]  DATA_VALUE      = 8'h00;
  localparam int          CAPS_D1_BIT     = 9;
  localparam int          CAPS_D2_BIT     = 10;
  localparam int          BR_BCC_BIT      = 7;
  localparam int          BR_STOP_BIT     = 6;
  localparam logic [1:0]  PS_D0           = 2'h0;
  localparam logic [1:0]  PS_D1           = 2'h1;
  localparam logic [1:0]  PS_D2           = 2'h2;
  localparam logic [1:0]  PS_D3HOT        = 2'h3;

  typedef struct packed {
    logic        ms1_m;
    logic        ms1_s;
    logic        ms0_m;
    logic        ms0_s;
    logic        bcc_m;
    logic        bcc_s;
    logic [1:0]  pstate;
    logic [31:0] rdata;
    logic        ack;
    logic        int_rst;
    logic        sec_run;
  } pmr_state_t;

  localparam pmr_state_t STATE_RESET = '{ms1_m: 1'b0, ms1_s: 1'b0, ms0_m: 1'b0, ms0_s: 1'b0,
                                         bcc_m: 1'b0, bcc_s: 1'b0, pstate: CSR_RESET[1:0],
                                         rdata: 32'h0000_0000, ack: 1'b0, int_rst: 1'b0,
                                         sec_run: 1'b1};
endpackage

/* File: design/pmr_regs.sv */
// Purpose: power-management capability, control/status, bridge-support and data registers
// Assumes: one primary clock; straps are asynchronous pins
// Notes:   secondary clock run level is an enable for the clock divider outside
`timescale 1ns/1ns
module pmr_regs
  import pmr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        upper_mode_strap_i,
  input  wire logic        lower_mode_strap_i,
  input  wire logic        bus_power_clock_strap_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  output logic [1:0]       power_state_o,
  output logic             internal_reset_o,
  output logic             sec_clk_run_o
);

  // Capability word from the synchronised straps
  function automatic logic [15:0] pmr_caps(input logic ms1, input logic ms0);
    logic [15:0] c;
    c = CAPS_FULL;
    if (ms1) begin
      c = CAPS_NONE;                                      // see [RQ1]
    end else begin
      c[CAPS_D2_BIT] = ~ms0;                              // see [RQ3]
      c[CAPS_D1_BIT] = ~ms0;                              // see [RQ3]
      c[2:0]         = ms0 ? VER_REV10 : VER_REV11;       // see [RQ7]
    end
    return c;
  endfunction

  // Whether a requested power state is advertised
  function automatic logic pmr_legal(input logic [1:0] ps, input logic ms1, input logic ms0);
    logic ok;
    ok = 1'b1;
    if (ms1) begin
      ok = (ps == PS_D0);
    end else if (ms0) begin
      ok = (ps == PS_D0) || (ps == PS_D3HOT);
    end
    return ok;
  endfunction

  pmr_state_t q;
  pmr_state_t next_q;
  logic       dw_caps;
  logic       dw_csr;
  logic       ps_wr;

  assign dw_caps = (cfg_addr_i[7:2] == CAPS_OFF[7:2]);
  assign dw_csr  = (cfg_addr_i[7:2] == CSR_OFF[7:2]);
  // Only the power-state field is writable
  assign ps_wr   = cfg_wr_i && dw_csr && cfg_be_i[0]
                   && pmr_legal(cfg_wdata_i[1:0], q.ms1_s, q.ms0_s);  // see [RQ18]

  // Next-state logic
  always_comb begin
    next_q       = q;
    next_q.ms1_m = upper_mode_strap_i;
    next_q.ms1_s = q.ms1_m;
    next_q.ms0_m = lower_mode_strap_i;
    next_q.ms0_s = q.ms0_m;
    next_q.bcc_m = bus_power_clock_strap_i;
    next_q.bcc_s = q.bcc_m;
    next_q.ack   = cfg_rd_i || cfg_wr_i;
    next_q.rdata = 32'h0000_0000;
    if (ps_wr) begin
      next_q.pstate = cfg_wdata_i[1:0];                   // see [RQ12] [RQ10]
    end
    if (cfg_rd_i && dw_caps) begin
      // Low half holds capability ID and next pointer, not kept here
      next_q.rdata[31:16] = pmr_caps(q.ms1_s, q.ms0_s);   // see [RQ2] [RQ4] [RQ5] [RQ6]
    end
    if (cfg_rd_i && dw_csr) begin
      next_q.rdata[31:24]            = DATA_VALUE;        // see [RQ17]
      next_q.rdata[16 + BR_BCC_BIT]  = q.bcc_s;           // see [RQ14]
      next_q.rdata[16 + BR_STOP_BIT] = q.bcc_s;           // see [RQ15]
      next_q.rdata[15:0]             = {14'h0000, q.pstate};  // see [RQ8] [RQ9] [RQ11] [RQ12]
    end
    // Internal reset pulse; register contents untouched by it
    next_q.int_rst = (q.pstate == PS_D3HOT) && (next_q.pstate == PS_D0);  // see [RQ13]
    // Secondary clocks run off the primary clock, so they stop with it
    next_q.sec_run = !(q.bcc_s && (q.pstate == PS_D3HOT));  // see [RQ15] [RQ16]
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= STATE_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign cfg_rdata_o      = q.rdata;
  assign cfg_ack_o        = q.ack;
  assign power_state_o    = q.pstate;
  assign internal_reset_o = q.int_rst;
  assign sec_clk_run_o    = q.sec_run;

  // Checks
  sequence caps_read_s;
    cfg_rd_i && dw_caps ##1 cfg_ack_o;
  endsequence

  sequence csr_read_s;
    cfg_rd_i && dw_csr ##1 cfg_ack_o;
  endsequence

  sequence d3_exit_s;
    q.pstate == PS_D3HOT ##1 q.pstate == PS_D0;
  endsequence

  caps_strap_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ1]
    caps_read_s |-> (cfg_rdata_o[31:16] == ($past(q.ms1_s) ? CAPS_NONE :
                     ($past(q.ms0_s) ? 16'h0001 : CAPS_FULL)))) else $error("capability word wrong");
  pme_field_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ2]
    caps_read_s |-> cfg_rdata_o[31:27] == 5'h00) else $error("PME support not zero");
  dstate_bits_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ3]
    caps_read_s |-> cfg_rdata_o[26:25] == {2{!$past(q.ms0_s) && !$past(q.ms1_s)}})
    else $error("D1/D2 support bits wrong");
  caps_resv_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ4]
    caps_read_s |-> cfg_rdata_o[24:22] == 3'h0) else $error("reserved capability bits set");
  caps_flags_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ5]
    caps_read_s |-> cfg_rdata_o[21:19] == 3'h0) else $error("DSI/aux/PME clock bits set");
  caps_ver_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ7]
    caps_read_s |-> cfg_rdata_o[18:16] == (($past(q.ms0_s) || $past(q.ms1_s)) ? VER_REV10 : VER_REV11))
    else $error("version field wrong");
  csr_upper_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ11]
    csr_read_s |-> cfg_rdata_o[15:2] == 14'h0000 && cfg_rdata_o[31:24] == DATA_VALUE)
    else $error("read-only control bits set");
  ps_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ12]
    ps_wr |=> power_state_o == $past(cfg_wdata_i[1:0]) ##1 cfg_rdata_o[1:0] == power_state_o || !cfg_ack_o
    || !$past(cfg_rd_i)) else $error("power state write lost");
  d3_reset_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ13]
    d3_exit_s |-> internal_reset_o ##1 !internal_reset_o) else $error("internal reset pulse wrong");
  bridge_bits_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ14]
    csr_read_s |-> cfg_rdata_o[23:22] == {2{$past(q.bcc_s)}} && cfg_rdata_o[21:16] == 6'h00)
    else $error("bridge support byte wrong");
  clk_stop_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ15]
    (q.bcc_s && power_state_o == PS_D3HOT) |=> !sec_clk_run_o) else $error("secondary clocks not stopped");
  ro_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // see [RQ18]
    cfg_wr_i && !ps_wr |=> $stable(power_state_o)) else $error("read-only write took effect");

endmodule // pmr_regs

/* File: verification/pmr_host.sv */
// Purpose: host model issuing configuration reads and writes
// Assumes: one-cycle strobes, answer one cycle after the strobe edge
// Notes:   address and data are scrambled once released
`timescale 1ns/1ns
module pmr_host (
  input  wire logic        sys_clk_i,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        cfg_ack_i,
  output logic [7:0]       cfg_addr_o,
  output logic             cfg_rd_o,
  output logic             cfg_wr_o,
  output logic [3:0]       cfg_be_o,
  output logic [31:0]      cfg_wdata_o
);
  // Idle bus at time zero
  initial begin
    {cfg_addr_o, cfg_rd_o, cfg_wr_o, cfg_be_o, cfg_wdata_o} = '0;
  end

  // One access: strobe over one edge, answer taken 1 ns after that same edge
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge sys_clk_i);
    #1;
    {cfg_addr_o, cfg_be_o, cfg_wdata_o} = {addr, be, wdata};
    {cfg_rd_o, cfg_wr_o} = {!wr, wr};
    @(posedge sys_clk_i);
    #1;
    {cfg_rd_o, cfg_wr_o} = 2'h0;
    {cfg_addr_o, cfg_wdata_o} = {~addr, ~wdata};
    rdata = cfg_ack_i ? cfg_rdata_i : 32'hDEAD_BEEF;
  endtask
endmodule // pmr_host

/* File: verification/tb.sv */
// Purpose: self-checking bench for the power-management register bank
// Assumes: straps settle three edges after a change
// Notes:   expected words are built from the field layout
`timescale 1ns/1ns
module tb;
  import pmr_pkg::*;
  logic        sys_clk_i, reset_n_i, up, lo, bcc, rd, wr, ack, irst, srun;
  logic [7:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  pst;
  int          n_errors, total_checks;

  pmr_regs dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .upper_mode_strap_i(up),
    .lower_mode_strap_i(lo), .bus_power_clock_strap_i(bcc), .cfg_addr_i(addr), .cfg_rd_i(rd),
    .cfg_wr_i(wr), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
    .power_state_o(pst), .internal_reset_o(irst), .sec_clk_run_o(srun));
  pmr_host host (.sys_clk_i(sys_clk_i), .cfg_rdata_i(rdata), .cfg_ack_i(ack), .cfg_addr_o(addr),
    .cfg_rd_o(rd), .cfg_wr_o(wr), .cfg_be_o(be), .cfg_wdata_o(wdata));

  // 50 ns clock
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Set straps, wait for sync, read capability word and bridge byte
  task automatic strap(input logic u, input logic l, input logic b);
    {up, lo, bcc} = {u, l, b};
    repeat (3) @(posedge sys_clk_i);
    host.access(1'b0, CAPS_OFF, 4'hF, 32'h0, d);
    chk(d[31:16], u ? CAPS_NONE : {5'h00, ~l, ~l, 6'h00, l ? VER_REV10 : VER_REV11});
    host.access(1'b0, CSR_OFF, 4'hF, 32'h0, d);
    chk(d[31:16], {8'h00, b, b, 6'h00});
  endtask

  // Write state with all bits above the state field set, then check state and whole dword
  task automatic pw(input logic [1:0] s, input logic [3:0] b, input logic [1:0] exp);
    host.access(1'b1, CSR_OFF, b, 32'hFFFF_FFFC | {30'h0, s}, d);
    chk(pst, exp);
    host.access(1'b0, CSR_OFF, 4'hF, 32'h0, d);
    chk(d, {8'h00, bcc, bcc, 6'h00, 14'h0000, exp});
  endtask

  // Main sequence
  initial begin
    {reset_n_i, up, lo, bcc, n_errors, total_checks} = '0;
    repeat (2) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    chk({pst, srun}, 3'h1);
    for (int i = 0; i < 8; i++) strap(i[2], i[1], i[0]);
    strap(1'b0, 1'b0, 1'b1);
    for (int s = 1; s < 4; s++) pw(s[1:0], 4'h1, s[1:0]);
    chk(srun, 1'b0);
    host.access(1'b1, CSR_OFF, 4'h1, 32'h0, d);
    chk({pst, irst}, 3'h1);
    @(posedge sys_clk_i);
    #1 chk({irst, srun}, 2'h1);
    pw(2'h2, 4'hE, 2'h0);
    strap(1'b0, 1'b1, 1'b0);
    pw(2'h1, 4'h1, 2'h0);
    pw(2'h3, 4'h1, 2'h3);
    chk(srun, 1'b1);
    pw(2'h0, 4'h1, 2'h0);
    strap(1'b1, 1'b0, 1'b1);
    pw(2'h3, 4'h1, 2'h0);
    host.access(1'b0, 8'hF0, 4'hF, 32'h0, d);
    chk(d, 32'h0);
    end_of_test();
  end

  // Watchdog well beyond the expected 120 or so cycles
  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule // tb
